// ---- verilog/pio_line_ctrl.v ----
`include "pio_regs.vh"
module pio_line_ctrl #(
    parameter WIDTH = 32
) (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite slave.
    input wire [7:0] s_awaddr,
    input wire s_awvalid,
    output wire s_awready,
    input wire [31:0] s_wdata,
    input wire [3:0] s_wstrb,
    input wire s_wvalid,
    output wire s_wready,
    output wire [1:0] s_bresp,
    output wire s_bvalid,
    input wire s_bready,
    input wire [7:0] s_araddr,
    input wire s_arvalid,
    output wire s_arready,
    output wire [31:0] s_rdata,
    output wire [1:0] s_rresp,
    output wire s_rvalid,
    input wire s_rready,
    // External lines.
    input wire [WIDTH-1:0] line_in,
    output reg [WIDTH-1:0] line_out,
    output reg [WIDTH-1:0] line_oe_n,
    // Interrupt request.
    output reg irq
);
    wire wr_stb;
    wire [7:0] wr_addr;
    wire [31:0] wr_data;
    wire rd_stb;
    wire [7:0] rd_addr;
    reg [31:0] rd_data;
    reg rd_ok;
    reg wr_ok;
    reg [WIDTH-1:0] dir_state;
    reg [WIDTH-1:0] filt_state;
    reg [WIDTH-1:0] lvl_state;
    reg [WIDTH-1:0] mask_state;
    reg [WIDTH-1:0] flags;
    reg [WIDTH-1:0] od_state;
    reg [WIDTH-1:0] wperm_state;
    reg [WIDTH-1:0] pin_sync;
    reg [WIDTH-1:0] pin_sample;
    reg [WIDTH-1:0] prev_level;
    reg primed;
    wire [WIDTH-1:0] filt_level;
    wire [WIDTH-1:0] w;
    wire [WIDTH-1:0] change;

    assign w = wr_data[WIDTH-1:0];

    pio_axil_slave pio_axil_slave_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_ok(wr_ok),
        .rd_stb(rd_stb),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    pio_glitch_filter #(
        .WIDTH(WIDTH),
        .CYCLES(`PIO_FILT_CYCLES)
    ) pio_glitch_filter_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw(pin_sync),
        .enable(filt_state),
        .level(filt_level)
    );

    // Write address decode answers OKAY for every writable offset; read-only offsets get SLVERR.
    always @*
    begin
        if (wr_addr == `PIO_OFF_DIR_ENABLE || wr_addr == `PIO_OFF_DIR_DISABLE)
            wr_ok = 1'b1;
        else if (wr_addr == `PIO_OFF_FILT_EN || wr_addr == `PIO_OFF_FILT_DIS)
            wr_ok = 1'b1;
        else if (wr_addr == `PIO_OFF_LVL_SET || wr_addr == `PIO_OFF_LVL_CLR)
            wr_ok = 1'b1;
        else if (wr_addr == `PIO_OFF_LVL_STATE)
            wr_ok = 1'b1;
        else if (wr_addr == `PIO_OFF_IRQ_UNMASK || wr_addr == `PIO_OFF_IRQ_MASK)
            wr_ok = 1'b1;
        else if (wr_addr == `PIO_OFF_OD_EN || wr_addr == `PIO_OFF_OD_DIS)
            wr_ok = 1'b1;
        else if (wr_addr == `PIO_OFF_WPERM_EN || wr_addr == `PIO_OFF_WPERM_DIS)
            wr_ok = 1'b1;
        else
            wr_ok = 1'b0;
    end

    // Read mux; write-only offsets read as zero.
    always @*
    begin
        rd_data = 32'h00000000;
        rd_ok = 1'b1;
        if (rd_addr == `PIO_OFF_DIR_STATE)
            rd_data[WIDTH-1:0] = dir_state;
        else if (rd_addr == `PIO_OFF_FILT_STATE)
            rd_data[WIDTH-1:0] = filt_state;
        else if (rd_addr == `PIO_OFF_LVL_STATE)
            rd_data[WIDTH-1:0] = lvl_state;
        else if (rd_addr == `PIO_OFF_PIN_SAMPLE)
            rd_data[WIDTH-1:0] = pin_sample;
        else if (rd_addr == `PIO_OFF_IRQ_MSTATE)
            rd_data[WIDTH-1:0] = mask_state;
        else if (rd_addr == `PIO_OFF_IRQ_FLAGS)
            rd_data[WIDTH-1:0] = flags;
        else if (rd_addr == `PIO_OFF_OD_STATE)
            rd_data[WIDTH-1:0] = od_state;
        else if (rd_addr == `PIO_OFF_WPERM_STATE)
            rd_data[WIDTH-1:0] = wperm_state;
        else if (wr_ok_read(rd_addr))
            rd_data = 32'h00000000;
        else
            rd_ok = 1'b0;
    end

    function wr_ok_read;
        input [7:0] a;
        begin
            wr_ok_read = (a == `PIO_OFF_DIR_ENABLE) || (a == `PIO_OFF_DIR_DISABLE) ||
                (a == `PIO_OFF_FILT_EN) || (a == `PIO_OFF_FILT_DIS) ||
                (a == `PIO_OFF_LVL_SET) || (a == `PIO_OFF_LVL_CLR) ||
                (a == `PIO_OFF_IRQ_UNMASK) || (a == `PIO_OFF_IRQ_MASK) ||
                (a == `PIO_OFF_OD_EN) || (a == `PIO_OFF_OD_DIS) ||
                (a == `PIO_OFF_WPERM_EN) || (a == `PIO_OFF_WPERM_DIS);
        end
    endfunction

    // A change is a difference between the conditioned level and its last value.
    assign change = primed ? (filt_level ^ prev_level) : {WIDTH{1'b0}};

    // Control registers.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dir_state <= `PIO_RESET_ZERO;
            filt_state <= `PIO_RESET_ZERO;
            lvl_state <= `PIO_RESET_ZERO;
            mask_state <= `PIO_RESET_ZERO;
            od_state <= `PIO_RESET_ZERO;
            wperm_state <= `PIO_RESET_ZERO;
        end
        else if (wr_stb)
        begin
            if (wr_addr == `PIO_OFF_DIR_ENABLE)
                dir_state <= dir_state | w;
            else if (wr_addr == `PIO_OFF_DIR_DISABLE)
                dir_state <= dir_state & ~w;
            else if (wr_addr == `PIO_OFF_FILT_EN)
                filt_state <= filt_state | w;
            else if (wr_addr == `PIO_OFF_FILT_DIS)
                filt_state <= filt_state & ~w;
            else if (wr_addr == `PIO_OFF_LVL_SET)
                lvl_state <= lvl_state | w;
            else if (wr_addr == `PIO_OFF_LVL_CLR)
                lvl_state <= lvl_state & ~w;
            else if (wr_addr == `PIO_OFF_LVL_STATE)
                lvl_state <= (lvl_state & ~wperm_state) | (w & wperm_state);
            else if (wr_addr == `PIO_OFF_IRQ_UNMASK)
                mask_state <= mask_state | w;
            else if (wr_addr == `PIO_OFF_IRQ_MASK)
                mask_state <= mask_state & ~w;
            else if (wr_addr == `PIO_OFF_OD_EN)
                od_state <= od_state | w;
            else if (wr_addr == `PIO_OFF_OD_DIS)
                od_state <= od_state & ~w;
            else if (wr_addr == `PIO_OFF_WPERM_EN)
                wperm_state <= wperm_state | w;
            else if (wr_addr == `PIO_OFF_WPERM_DIS)
                wperm_state <= wperm_state & ~w;
        end
    end

    // Pin sampling, change detection and sticky flags.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_sync <= `PIO_RESET_ZERO;
            pin_sample <= `PIO_RESET_ZERO;
            prev_level <= `PIO_RESET_ZERO;
            primed <= 1'b0;
            flags <= `PIO_RESET_ZERO;
        end
        else
        begin
            pin_sync <= line_in;
            pin_sample <= pin_sync;
            prev_level <= filt_level;
            primed <= 1'b1;
            if (rd_stb && rd_addr == `PIO_OFF_IRQ_FLAGS)
                flags <= change;
            else
                flags <= flags | change;
        end
    end

    // Pad drive and interrupt request.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            line_out <= `PIO_RESET_ZERO;
            line_oe_n <= {WIDTH{1'b1}};
            irq <= 1'b0;
        end
        else
        begin
            line_out <= lvl_state & ~od_state;
            line_oe_n <= ~(dir_state & ~(od_state & lvl_state));
            irq <= |(flags & mask_state);
        end
    end
endmodule // pio_line_ctrl

// ---- inc/pio_regs.vh ----
// Operation
// - Direction status: 0 input, 1 output
// - Filter enable write sets filter bits
// - Filter disable write clears filter bits
// - Filter status shows active filters
// - Set write drives line high
// - Clear write drives line low
// - Drive level status shows scheduled level
// - Drive level status readable, partly writable
// - Direct write only on permitted lines
// - Pin sample shows actual line level
// - Unmask write enables change interrupt
// - Mask write disables change interrupt
// - Mask status shows unmasked lines
// - Change flag set on detected change
// - Reading change flags clears them
// - Open-drain enable write selects open drain
// - Open-drain disable restores push-pull
// - Open drain never drives high
`ifndef PIO_REGS_VH
`define PIO_REGS_VH
`define PIO_OFF_DIR_ENABLE 8'h10
`define PIO_OFF_DIR_DISABLE 8'h14
`define PIO_OFF_DIR_STATE 8'h18
`define PIO_OFF_FILT_EN 8'h20
`define PIO_OFF_FILT_DIS 8'h24
`define PIO_OFF_FILT_STATE 8'h28
`define PIO_OFF_LVL_SET 8'h30
`define PIO_OFF_LVL_CLR 8'h34
`define PIO_OFF_LVL_STATE 8'h38
`define PIO_OFF_PIN_SAMPLE 8'h3C
`define PIO_OFF_IRQ_UNMASK 8'h40
`define PIO_OFF_IRQ_MASK 8'h44
`define PIO_OFF_IRQ_MSTATE 8'h48
`define PIO_OFF_IRQ_FLAGS 8'h4C
`define PIO_OFF_OD_EN 8'h50
`define PIO_OFF_OD_DIS 8'h54
`define PIO_OFF_OD_STATE 8'h58
`define PIO_OFF_WPERM_EN 8'hA0
`define PIO_OFF_WPERM_DIS 8'hA4
`define PIO_OFF_WPERM_STATE 8'hA8
`define PIO_RESET_ZERO 32'h00000000
`define PIO_RESP_OKAY 2'b00
`define PIO_RESP_SLVERR 2'b10
`define PIO_FILT_CYCLES 2
`endif

// ---- verilog/pio_glitch_filter.v ----
`include "pio_regs.vh"
module pio_glitch_filter #(
    parameter WIDTH = 32,
    parameter CYCLES = `PIO_FILT_CYCLES
) (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // Per-line level path.
    input wire [WIDTH-1:0] raw,
    input wire [WIDTH-1:0] enable,
    output reg [WIDTH-1:0] level
);
    reg [WIDTH-1:0] held;
    reg [1:0] cnt [0:WIDTH-1];
    integer i;
    // A filtered line follows its input only after it stayed stable for CYCLES + 1 clocks.
    always @(posedge aclk)
    begin
        for (i = 0; i < WIDTH; i = i + 1)
        begin
            if (!aresetn)
            begin
                cnt[i] <= 2'h0;
                held[i] <= 1'b0;
                level[i] <= 1'b0;
            end
            else if (raw[i] != held[i])
            begin
                held[i] <= raw[i];
                cnt[i] <= 2'h0;
                if (!enable[i])
                    level[i] <= raw[i];
            end
            else if (!enable[i] || cnt[i] >= CYCLES - 1)
            begin
                level[i] <= held[i];
            end
            else
            begin
                cnt[i] <= cnt[i] + 2'h1;
            end
        end
    end
endmodule // pio_glitch_filter

// ---- verilog/pio_axil_slave.v ----
`include "pio_regs.vh"
module pio_axil_slave (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write channels.
    input wire [7:0] s_awaddr,
    input wire s_awvalid,
    output wire s_awready,
    input wire [31:0] s_wdata,
    input wire [3:0] s_wstrb,
    input wire s_wvalid,
    output wire s_wready,
    output reg [1:0] s_bresp,
    output reg s_bvalid,
    input wire s_bready,
    // AXI4-Lite read channels.
    input wire [7:0] s_araddr,
    input wire s_arvalid,
    output wire s_arready,
    output reg [31:0] s_rdata,
    output reg [1:0] s_rresp,
    output reg s_rvalid,
    input wire s_rready,
    // Register access strobes.
    output reg wr_stb,
    output reg [7:0] wr_addr,
    output reg [31:0] wr_data,
    input wire wr_ok,
    output wire rd_stb,
    output wire [7:0] rd_addr,
    input wire [31:0] rd_data,
    input wire rd_ok
);
    reg aw_held;
    reg w_held;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    assign s_awready = !aw_held && !s_bvalid;
    assign s_wready = !w_held && !s_bvalid;
    assign s_arready = !s_rvalid;
    assign rd_stb = s_arvalid && s_arready;
    assign rd_addr = s_araddr;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            wr_stb <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h00000000;
            s_bvalid <= 1'b0;
            s_bresp <= `PIO_RESP_OKAY;
            s_rvalid <= 1'b0;
            s_rresp <= `PIO_RESP_OKAY;
            s_rdata <= 32'h00000000;
        end
        else
        begin
            wr_stb <= 1'b0;
            if (s_awvalid && s_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_wdata;
            end
            if (aw_held && w_held && !wr_stb && !s_bvalid)
            begin
                wr_stb <= 1'b1;
                wr_addr <= aw_addr;
                wr_data <= w_data;
            end
            if (wr_stb)
            begin
                s_bvalid <= 1'b1;
                s_bresp <= wr_ok ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
            else if (s_bvalid && s_bready)
            begin
                s_bvalid <= 1'b0;
            end
            if (rd_stb)
            begin
                s_rvalid <= 1'b1;
                s_rdata <= rd_data;
                s_rresp <= rd_ok ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
            end
            else if (s_rvalid && s_rready)
            begin
                s_rvalid <= 1'b0;
            end
        end
    end
endmodule // pio_axil_slave

// ---- tb/pio_line_ctrl_checker.sv ----
module pio_line_ctrl_checker #(
    parameter WIDTH = 32
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes.
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic [1:0] s_bresp,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic s_rvalid,
    input wire logic s_rready,
    // Lines and request.
    input wire logic [WIDTH-1:0] line_oe_n,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    bvalid_follows_write_a: assert property (s_awvalid && s_awready && s_wvalid && s_wready
        |-> ##[1:3] s_bvalid) else $error("write answer missing");
    rvalid_follows_read_a: assert property (s_arvalid && s_arready |-> ##[1:2] s_rvalid)
        else $error("read answer missing");
    bresp_holds_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write answer dropped");
    rdata_holds_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read answer dropped");
    read_busy_a: assert property (s_rvalid |-> !s_arready)
        else $error("read taken while answer pending");
    write_busy_a: assert property (s_bvalid |-> !s_awready && !s_wready)
        else $error("write taken while answer pending");
    irq_reset_a: assert property ($rose(aresetn) |-> !irq)
        else $error("interrupt high after reset");
    lines_input_a: assert property ($rose(aresetn) |-> &line_oe_n)
        else $error("line driven after reset");

    cover property (s_bvalid && s_bready);
    cover property (s_rvalid && s_rready);
    cover property ($rose(irq));
endmodule // pio_line_ctrl_checker

bind pio_line_ctrl pio_line_ctrl_checker #(.WIDTH(WIDTH)) pio_line_ctrl_checker_inst (
    .aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .line_oe_n(line_oe_n), .irq(irq));

// ---- tb/pio_pin_model.sv ----
module pio_pin_model #(
    parameter WIDTH = 32
) (
    // Drive from the port.
    input wire logic [WIDTH-1:0] line_out,
    input wire logic [WIDTH-1:0] line_oe_n,
    // Level the outside world puts on released lines.
    input wire logic [WIDTH-1:0] ext_level,
    // Resulting pin levels.
    output logic [WIDTH-1:0] line_in
);
    timeunit 1ns;
    timeprecision 1ps;
    assign line_in = (line_out & ~line_oe_n) | (ext_level & line_oe_n);
endmodule // pio_pin_model

// ---- tb/tb_pio_line_ctrl.sv ----
`include "pio_regs.vh"
module tb_pio_line_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_awaddr = 8'h00;
    logic [7:0] s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h00000000;
    logic [3:0] s_wstrb = 4'hF;
    logic s_awvalid = 1'b0;
    logic s_wvalid = 1'b0;
    logic s_bready = 1'b0;
    logic s_arvalid = 1'b0;
    logic s_rready = 1'b0;
    logic [31:0] ext_level = 32'h00000000;
    wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
    wire [1:0] s_bresp, s_rresp;
    wire [31:0] s_rdata, line_in, line_out, line_oe_n;
    int num_errors = 0;
    int samples_checked = 0;

    always #5 aclk = ~aclk;

    pio_line_ctrl #(.WIDTH(32)) pio_line_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n),
        .irq(irq));
    pio_pin_model #(.WIDTH(32)) pio_pin_model_inst (.line_out(line_out),
        .line_oe_n(line_oe_n), .ext_level(ext_level), .line_in(line_in));

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er, input logic [31:0] ed);
        logic fin;
        logic ta;
        logic tw;
        logic tar;
        logic [1:0] rs;
        logic [31:0] rv;
        int cyc;
        fin = 1'b0;
        cyc = 0;
        @(posedge aclk);
        if (w)
        begin
            s_awaddr <= a;
            s_wdata <= d;
            s_awvalid <= 1'b1;
            s_wvalid <= 1'b1;
            s_bready <= 1'b1;
        end
        else
        begin
            s_araddr <= a;
            s_arvalid <= 1'b1;
            s_rready <= 1'b1;
        end
        while (!fin)
        begin
            @(negedge aclk);
            ta = s_awvalid & s_awready;
            tw = s_wvalid & s_wready;
            tar = s_arvalid & s_arready;
            rs = w ? s_bresp : s_rresp;
            rv = s_rdata;
            fin = w ? (s_bvalid & s_bready) : (s_rvalid & s_rready);
            @(posedge aclk);
            if (ta) s_awvalid <= 1'b0;
            if (tw) s_wvalid <= 1'b0;
            if (tar) s_arvalid <= 1'b0;
            if (fin) s_bready <= 1'b0;
            if (fin) s_rready <= 1'b0;
            cyc++;
        end
        cmp("latency", w ? 32'h00000004 : 32'h00000002, cyc);
        cmp("resp", {30'h0, er}, {30'h0, rs});
        if (!w && er == `PIO_RESP_OKAY)
            cmp("rdata", ed, rv);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, `PIO_RESP_OKAY, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, `PIO_RESP_OKAY, e);
    endtask

    task automatic t_reset;
        logic [7:0] regs [6] = '{`PIO_OFF_DIR_STATE, `PIO_OFF_FILT_STATE, `PIO_OFF_LVL_STATE,
            `PIO_OFF_IRQ_MSTATE, `PIO_OFF_IRQ_FLAGS, `PIO_OFF_OD_STATE};
        @(negedge aclk);
        cmp("oe_n", 32'hFFFFFFFF, line_oe_n);
        cmp("out", 32'h00000000, line_out);
        cmp("irq", 32'h0, {31'h0, irq});
        foreach (regs[i]) rd(regs[i], 32'h0);
    endtask

    task automatic t_filter;
        wr(`PIO_OFF_FILT_EN, 32'h00000C00);
        wr(`PIO_OFF_FILT_DIS, 32'h00000800);
        rd(`PIO_OFF_FILT_STATE, 32'h00000400);
    endtask

    task automatic t_irq;
        wr(`PIO_OFF_IRQ_UNMASK, 32'h00000300);
        wr(`PIO_OFF_IRQ_MASK, 32'h00000200);
        rd(`PIO_OFF_IRQ_MSTATE, 32'h00000100);
        @(posedge aclk);
        ext_level <= 32'h00000500;
        @(posedge aclk);
        ext_level <= 32'h00000000;
        repeat (8) @(posedge aclk);
        @(negedge aclk);
        cmp("irq", 32'h1, {31'h0, irq});
        @(posedge aclk);
        ext_level <= 32'h00000200;
        repeat (8) @(posedge aclk);
        rd(`PIO_OFF_IRQ_FLAGS, 32'h00000300);
        rd(`PIO_OFF_IRQ_FLAGS, 32'h00000000);
        @(negedge aclk);
        cmp("irq", 32'h0, {31'h0, irq});
    endtask

    task automatic t_drive;
        wr(`PIO_OFF_DIR_ENABLE, 32'h000000FF);
        wr(`PIO_OFF_LVL_SET, 32'h000000A5);
        wr(`PIO_OFF_LVL_CLR, 32'h00000005);
        rd(`PIO_OFF_LVL_STATE, 32'h000000A0);
        rd(`PIO_OFF_DIR_STATE, 32'h000000FF);
        @(negedge aclk);
        cmp("oe_n", 32'hFFFFFF00, line_oe_n);
        cmp("out", 32'h000000A0, line_out);
        wr(`PIO_OFF_WPERM_EN, 32'h0000000F);
        rd(`PIO_OFF_WPERM_STATE, 32'h0000000F);
        wr(`PIO_OFF_LVL_STATE, 32'h0000005F);
        rd(`PIO_OFF_LVL_STATE, 32'h000000AF);
        ext_level <= 32'h5A5A0000;
        repeat (3) @(posedge aclk);
        rd(`PIO_OFF_PIN_SAMPLE, 32'h5A5A00AF);
    endtask

    task automatic t_drain;
        wr(`PIO_OFF_OD_EN, 32'h00000013);
        rd(`PIO_OFF_OD_STATE, 32'h00000013);
        @(negedge aclk);
        cmp("oe_n", 32'hFFFFFF03, line_oe_n);
        cmp("out", 32'h000000AC, line_out);
        rd(`PIO_OFF_PIN_SAMPLE, 32'h5A5A00AC);
        wr(`PIO_OFF_OD_DIS, 32'h00000001);
        rd(`PIO_OFF_OD_STATE, 32'h00000012);
        @(negedge aclk);
        cmp("oe_n", 32'hFFFFFF02, line_oe_n);
        cmp("out", 32'h000000AD, line_out);
    endtask

    task automatic t_bus;
        xfer(1'b1, 8'h1C, 32'hFFFFFFFF, `PIO_RESP_SLVERR, 32'h0);
        xfer(1'b0, 8'h1C, 32'h0, `PIO_RESP_SLVERR, 32'h0);
        rd(`PIO_OFF_LVL_SET, 32'h00000000);
        rd(`PIO_OFF_LVL_STATE, 32'h000000AF);
    endtask

    // Reset in mid-run with quiet pins must bring direction, filter, level, mask, flag and open-drain status back to zero.
    task automatic t_rerun;
        ext_level <= 32'h00000000;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
    endtask

    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_filter();
        t_irq();
        t_drive();
        t_drain();
        t_bus();
        t_rerun();
        print_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        print_verdict();
    end
endmodule // tb_pio_line_ctrl
